// *** core/acc_conv_cfg.v ***
// adc conversion setup and ready pin / coefficient setup registers
// assumes a two-wire slave front end giving byte writes/reads on ref_clk_in
// Notes on behaviour
// R1 - chop enable set turns input chopping on and roughly doubles conversion time.
// R2 - the modulator runs at oscillator divided by 2, 4, 8 or 16 for codes 0 to 3.
// R3 - line rejection code picks 50/60 Hz, 50 Hz or 60 Hz filtering, code 3 reserved.
// R4 - decimation is 768/384/192/96 for rejection 0 or 1 and 640/320/160/80 for 2.
// R5 - conversion time scales with decimation: 16.2 ms single, 5 ms continuous at maximum.
// R6 - in general-purpose mode the direction bit makes the ready pin input (0) or output (1).
// R7 - the level bit reads the sampled pin as input and holds the driven level as output.
// R8 - pin function picks push-pull ready, open-drain ready, general-purpose, or reserved.
// R9 - swap bit 0 sends main coefficients to amplifier results, 1 exchanges the sets.
// R10 - conversion setup sits at address 0x13 with its image at eeprom word 0x005.
// R11 - the host must not write reserved rejection or pin function codes.
`timescale 1ns/1ps
`include "acc_defs.vh"
module acc_conv_cfg
#(
    parameter SINGLE_CYCLES = (`ACC_SINGLE_US * `ACC_CLK_MHZ),
    parameter CONT_CYCLES   = (`ACC_CONT_US * `ACC_CLK_MHZ)
)
(
    input  wire        ref_clk_in,
    input  wire        nrst_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    input  wire [7:0]  reg_addr_in,
    input  wire [7:0]  reg_wdata_in,
    output reg  [7:0]  reg_rdata_out,
    output reg         reg_ack_out,
    output wire [9:0]  reg_eeprom_addr_out,
    input  wire        osc_in,
    input  wire        ready_status_in,
    input  wire        continuous_in,
    input  wire        ready_pin_in,
    output reg         ready_pin_out,
    output reg         ready_pin_oe_out,
    output wire        mod_tick_out,
    output reg         chop_enable_out,
    output reg  [1:0]  line_reject_select_out,
    output reg  [9:0]  decimation_ratio_out,
    output reg  [23:0] conv_time_cycles_out,
    output reg         amp_uses_aux_coef_out,
    output reg         aux_uses_aux_coef_out
);

reg  [7:0]  adc_conversion_setup;
reg  [7:0]  ready_pin_and_coef_setup;
reg         osc_meta;
reg         osc_sync;
reg         osc_prev;
reg         pin_meta;
reg         pin_sync;
reg  [9:0]  next_ratio;
reg  [23:0] next_time;
wire [1:0]  pin_func;
wire        pin_dir;
wire        pin_lvl;
wire        osc_tick;
wire        hit_conv;
wire        hit_pin;

// decimation per rejection/oversampling combination; reserved gives 0
function [9:0] acc_ratio;
    input [1:0] line_reject_select;
    input [1:0] dec;
    begin
        case (line_reject_select)
            `ACC_REJ_BOTH, `ACC_REJ_50: acc_ratio = `ACC_DEC_50_MAX >> dec; // R4
            `ACC_REJ_60:                acc_ratio = `ACC_DEC_60_MAX >> dec; // R4
            default:                    acc_ratio = 10'd0; // R3
        endcase
    end
endfunction

// conversion cycles from base count, scaled by ratio and doubled with chop
function [23:0] acc_time;
    input [31:0] base;
    input [9:0]  ratio;
    input        chop;
    reg   [41:0] prod;
    begin
        prod     = base * ratio / 32'd768;
        acc_time = chop ? prod[22:0] << 1 : prod[23:0]; // R1 R5
    end
endfunction

// ===========================================================
// synchronisers for pin-side inputs
always @(posedge ref_clk_in or negedge nrst_in)
begin
    if (!nrst_in)
    begin
        osc_meta <= 1'b0;
        osc_sync <= 1'b0;
        osc_prev <= 1'b0;
        pin_meta <= 1'b0;
        pin_sync <= 1'b0;
    end
    else
    begin
        osc_meta <= osc_in;
        osc_sync <= osc_meta;
        osc_prev <= osc_sync;
        pin_meta <= ready_pin_in;
        pin_sync <= pin_meta;
    end
end

assign osc_tick = osc_sync & ~osc_prev;

// ===========================================================
// register access
assign hit_conv = (reg_addr_in == `ACC_ADDR_CONV); // R10
assign hit_pin  = (reg_addr_in == `ACC_ADDR_PIN);
assign reg_eeprom_addr_out = hit_pin ? `ACC_EEPROM_PIN : `ACC_EEPROM_CONV; // R10

assign pin_func = ready_pin_and_coef_setup[`ACC_FUNC_HI:`ACC_FUNC_LO];
assign pin_dir  = ready_pin_and_coef_setup[`ACC_DIR_BIT];
assign pin_lvl  = ready_pin_and_coef_setup[`ACC_LVL_BIT];

// writes store only defined bits; reserved codes are stored as written,
// the host is trusted not to send them
always @(posedge ref_clk_in or negedge nrst_in)
begin
    if (!nrst_in)
    begin
        adc_conversion_setup     <= `ACC_CONV_RESET;
        ready_pin_and_coef_setup <= `ACC_PIN_RESET;
        reg_ack_out              <= 1'b0;
        reg_rdata_out            <= 8'h00;
    end
    else
    begin
        reg_ack_out <= reg_wr_in | reg_rd_in;
        if (reg_wr_in && hit_conv)
            adc_conversion_setup <= reg_wdata_in & `ACC_CONV_MASK;
        if (reg_wr_in && hit_pin)
        begin
            ready_pin_and_coef_setup <= reg_wdata_in & `ACC_PIN_MASK; // R11
            // a write that selects gpio input keeps the sampled level: pin update wins
            if (reg_wdata_in[`ACC_FUNC_HI:`ACC_FUNC_LO] == `ACC_FUNC_GPIO &&
                !reg_wdata_in[`ACC_DIR_BIT])
                ready_pin_and_coef_setup[`ACC_LVL_BIT] <= pin_sync; // R7
        end
        else if (pin_func == `ACC_FUNC_GPIO && !pin_dir)
            ready_pin_and_coef_setup[`ACC_LVL_BIT] <= pin_sync; // R7
        if (reg_rd_in)
        begin
            if (hit_conv)
                reg_rdata_out <= adc_conversion_setup;
            else if (hit_pin)
                reg_rdata_out <= ready_pin_and_coef_setup;
            else
                reg_rdata_out <= 8'h00;
        end
    end
end

// ===========================================================
// decoded configuration
always @*
begin
    next_ratio = acc_ratio(adc_conversion_setup[`ACC_REJ_HI:`ACC_REJ_LO],
                           adc_conversion_setup[`ACC_DEC_HI:`ACC_DEC_LO]);
    next_time  = acc_time(continuous_in ? CONT_CYCLES : SINGLE_CYCLES, next_ratio,
                          adc_conversion_setup[`ACC_CHOP_BIT]); // R5
end

// outputs registered so downstream sees a clean change one cycle after write
always @(posedge ref_clk_in or negedge nrst_in)
begin
    if (!nrst_in)
    begin
        chop_enable_out        <= 1'b0;
        line_reject_select_out <= 2'h0;
        decimation_ratio_out   <= 10'd0;
        conv_time_cycles_out   <= 24'h000000;
        amp_uses_aux_coef_out  <= 1'b0;
        aux_uses_aux_coef_out  <= 1'b1;
    end
    else
    begin
        chop_enable_out        <= adc_conversion_setup[`ACC_CHOP_BIT]; // R1
        line_reject_select_out <= adc_conversion_setup[`ACC_REJ_HI:`ACC_REJ_LO]; // R3
        decimation_ratio_out   <= next_ratio; // R4
        conv_time_cycles_out   <= next_time;
        amp_uses_aux_coef_out  <= ready_pin_and_coef_setup[`ACC_SWAP_BIT]; // R9
        aux_uses_aux_coef_out  <= ~ready_pin_and_coef_setup[`ACC_SWAP_BIT]; // R9
    end
end

// ===========================================================
// ready pin driver; reserved function releases the pin as a safe choice
always @(posedge ref_clk_in or negedge nrst_in)
begin
    if (!nrst_in)
    begin
        ready_pin_out    <= 1'b0;
        ready_pin_oe_out <= 1'b0;
    end
    else
    begin
        case (pin_func)
            `ACC_FUNC_PUSHPULL:
            begin
                ready_pin_out    <= ready_status_in; // R8
                ready_pin_oe_out <= 1'b1;
            end
            `ACC_FUNC_OPENDRAIN:
            begin
                ready_pin_out    <= 1'b0; // R8
                ready_pin_oe_out <= ~ready_status_in;
            end
            `ACC_FUNC_GPIO:
            begin
                ready_pin_out    <= pin_lvl; // R7
                ready_pin_oe_out <= pin_dir; // R6
            end
            default:
            begin
                ready_pin_out    <= 1'b0;
                ready_pin_oe_out <= 1'b0;
            end
        endcase
    end
end

// ===========================================================
// modulator clock divider
acc_clk_div u_div
(
    .ref_clk_in   (ref_clk_in),
    .nrst_in      (nrst_in),
    .osc_tick_in  (osc_tick),
    .div_code_in  (adc_conversion_setup[`ACC_DIV_HI:`ACC_DIV_LO]),
    .mod_tick_out (mod_tick_out)
);

endmodule

// *** core/acc_defs.vh ***
// register offsets, field positions, reset values and timing figures
// for the adc conversion setup and ready pin / coefficient setup logic
`ifndef ACC_DEFS_VH
`define ACC_DEFS_VH

// register map (byte-wide registers on the two-wire slave's address space)
`define ACC_ADDR_CONV        8'h13
`define ACC_ADDR_PIN         8'h14
`define ACC_EEPROM_CONV      10'h005
`define ACC_EEPROM_PIN       10'h006

// adc_conversion_setup fields
`define ACC_CHOP_BIT         6
`define ACC_DIV_HI           5
`define ACC_DIV_LO           4
`define ACC_REJ_HI           3
`define ACC_REJ_LO           2
`define ACC_DEC_HI           1
`define ACC_DEC_LO           0
`define ACC_CONV_RESET       8'h00
`define ACC_CONV_MASK        8'h7F

// ready_pin_and_coef_setup fields
`define ACC_DIR_BIT          7
`define ACC_LVL_BIT          6
`define ACC_FUNC_HI          5
`define ACC_FUNC_LO          4
`define ACC_SWAP_BIT         0
`define ACC_PIN_RESET        8'h00
`define ACC_PIN_MASK         8'hF1

// ready pin function codes
`define ACC_FUNC_PUSHPULL    2'h0
`define ACC_FUNC_OPENDRAIN   2'h1
`define ACC_FUNC_GPIO        2'h2

// line rejection codes
`define ACC_REJ_BOTH         2'h0
`define ACC_REJ_50           2'h1
`define ACC_REJ_60           2'h2

// decimation ratios at the largest setting
`define ACC_DEC_50_MAX       10'd768
`define ACC_DEC_60_MAX       10'd640

// timing: nominal single and continuous conversion at ratio 768, chop off, in microseconds
`define ACC_SINGLE_US        16200
`define ACC_CONT_US          5000
`define ACC_CLK_MHZ          125

`endif

// *** core/acc_clk_div.v ***
// modulator clock enable generator: divides the oscillator by 2,4,8,16
// assumes the oscillator is already sampled into the ref_clk_in domain
`timescale 1ns/1ps
module acc_clk_div
(
    input  wire       ref_clk_in,
    input  wire       nrst_in,
    input  wire       osc_tick_in,
    input  wire [1:0] div_code_in,
    output reg        mod_tick_out
);

reg  [3:0] div_cnt;
wire [3:0] div_last;

// terminal count per code: 2^(code+1) oscillator ticks
assign div_last = (4'h2 << div_code_in) - 4'h1;

// ===========================================================
// divider
// counter restarts when it reaches or passes the terminal value, so a code change
// never stalls the divider for a full wrap of 16
always @(posedge ref_clk_in or negedge nrst_in)
begin
    if (!nrst_in)
    begin
        div_cnt      <= 4'h0;
        mod_tick_out <= 1'b0;
    end
    else
    begin
        mod_tick_out <= 1'b0;
        if (osc_tick_in)
        begin
            if (div_cnt >= div_last)
            begin
                div_cnt      <= 4'h0;
                mod_tick_out <= 1'b1; // R2
            end
            else
                div_cnt <= div_cnt + 4'h1;
        end
    end
end

endmodule

// *** dv/acc_far_end.sv ***
// far-side model: oscillator source and the board wire on the ready pin
// assumes one clock; a released pin shows what the host drives
`timescale 1ns/1ps
module acc_far_end
(
    input  wire ref_clk_in,
    input  wire pin_oe_in,
    input  wire pin_drv_in,
    input  wire ext_lvl_in,
    output reg  osc_out,
    output wire pin_lvl_out
);
    integer n = 0;
    initial osc_out = 1'b0;
    // oscillator toggles every 3 cycles, a period of 6 cycles
    always @(posedge ref_clk_in)
    begin
        n <= (n == 2) ? 0 : n + 1;
        if (n == 2)
            osc_out <= !osc_out;
    end
    // the driving end wins; otherwise the host level shows
    assign pin_lvl_out = pin_oe_in ? pin_drv_in : ext_lvl_in;
endmodule

// *** dv/acc_conv_cfg_checker.sv ***
// assertions on the setup block's ports
// assumes single clock, active-low asynchronous reset
`timescale 1ns/1ps
module acc_chk
#(
    parameter SINGLE_CYCLES = 768,
    parameter CONT_CYCLES   = 384
)
(
    input wire        ref_clk_in,
    input wire        nrst_in,
    input wire        reg_wr_in,
    input wire        reg_rd_in,
    input wire [7:0]  reg_addr_in,
    input wire [7:0]  reg_wdata_in,
    input wire        reg_ack_out,
    input wire [9:0]  reg_eeprom_addr_out,
    input wire        continuous_in,
    input wire        ready_pin_out,
    input wire        ready_pin_oe_out,
    input wire        mod_tick_out,
    input wire        chop_enable_out,
    input wire [9:0]  decimation_ratio_out,
    input wire [23:0] conv_time_cycles_out,
    input wire        amp_uses_aux_coef_out,
    input wire        aux_uses_aux_coef_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    // ===============================
    // expected ratio; reserved code gives 0
    function [9:0] rat(input [3:0] x);
        rat = (x[3:2] == 2'h3) ? 10'h0 : ((x[3:2] == 2'h2) ? 640 : 768) >> x[1:0];
    endfunction
    sequence s_conv; reg_wr_in && reg_addr_in == 8'h13; endsequence
    sequence s_pin; reg_wr_in && reg_addr_in == 8'h14; endsequence
    // ===============================
    a_ack_pulse: assert property ((reg_wr_in || reg_rd_in) |=> reg_ack_out)
        else $error("ack missing");
    a_ack_idle: assert property (!(reg_wr_in || reg_rd_in) |=> !reg_ack_out)
        else $error("ack without request");
    a_eeprom_map: assert property (reg_addr_in == 8'h13 |-> reg_eeprom_addr_out == 10'h005)
        else $error("eeprom image address wrong");
    a_chop_bit: assert property (s_conv ##3 1 |-> chop_enable_out == $past(reg_wdata_in[6], 3))
        else $error("chop enable wrong");
    a_ratio_map: assert property (s_conv ##3 1 |->
        decimation_ratio_out == rat($past(reg_wdata_in[3:0], 3)))
        else $error("decimation ratio wrong");
    a_time_scale: assert property (s_conv ##3 1 |-> conv_time_cycles_out ==
        (((continuous_in ? CONT_CYCLES : SINGLE_CYCLES) * rat($past(reg_wdata_in[3:0], 3)) / 768)
        << $past(reg_wdata_in[6], 3)))
        else $error("conversion time wrong");
    a_swap_pair: assert property (amp_uses_aux_coef_out != aux_uses_aux_coef_out)
        else $error("coefficient sets not exclusive");
    // the pair above cannot catch a stuck swap; this ties it to the written bit
    a_swap_follow: assert property (s_pin ##3 1 |->
        amp_uses_aux_coef_out == $past(reg_wdata_in[0], 3))
        else $error("coefficient swap not applied");
    a_gpio_out: assert property (s_pin ##0 (reg_wdata_in[7] && reg_wdata_in[5:4] == 2'h2) ##3 1
        |-> ready_pin_oe_out && ready_pin_out == $past(reg_wdata_in[6], 3))
        else $error("gpio output wrong");
    a_gpio_in: assert property (s_pin ##0 (!reg_wdata_in[7] && reg_wdata_in[5:4] == 2'h2) ##3 1
        |-> !ready_pin_oe_out)
        else $error("gpio input still driven");
    a_od_low: assert property (s_pin ##0 reg_wdata_in[5:4] == 2'h1 ##3 1 |-> !ready_pin_out)
        else $error("open drain drives high");
    a_tick_gap: assert property (mod_tick_out |=> !mod_tick_out)
        else $error("modulator tick too long");
endmodule
bind acc_conv_cfg acc_chk
#(
    .SINGLE_CYCLES (SINGLE_CYCLES),
    .CONT_CYCLES   (CONT_CYCLES)
)
u_acc_chk
(
    .ref_clk_in            (ref_clk_in),
    .nrst_in               (nrst_in),
    .reg_wr_in             (reg_wr_in),
    .reg_rd_in             (reg_rd_in),
    .reg_addr_in           (reg_addr_in),
    .reg_wdata_in          (reg_wdata_in),
    .reg_ack_out           (reg_ack_out),
    .reg_eeprom_addr_out   (reg_eeprom_addr_out),
    .continuous_in         (continuous_in),
    .ready_pin_out         (ready_pin_out),
    .ready_pin_oe_out      (ready_pin_oe_out),
    .mod_tick_out          (mod_tick_out),
    .chop_enable_out       (chop_enable_out),
    .decimation_ratio_out  (decimation_ratio_out),
    .conv_time_cycles_out  (conv_time_cycles_out),
    .amp_uses_aux_coef_out (amp_uses_aux_coef_out),
    .aux_uses_aux_coef_out (aux_uses_aux_coef_out)
);

// *** dv/acc_conv_cfg_tb.sv ***
// self-checking bench for the setup block
// assumes the far-side model supplies oscillator and pin wire
`timescale 1ns/1ps
module adc_conversion_config_tb;
    reg clk = 0, nrst = 0, wr = 0, rd = 0, st = 0, cont = 0, ext = 0;
    reg [7:0] addr = 8'h00, wd = 8'h00, d;
    reg [1:0] f;
    wire [7:0] rdata;
    wire ack, pout, poe, tick, chop, amp, aux, osc, plvl;
    wire [1:0] line_reject_select;
    wire [9:0] ratio, eep;
    wire [23:0] ctime;
    integer n_mismatch = 0, total_checks = 0, i, c;
    // small counts keep the run short
    acc_conv_cfg #(.SINGLE_CYCLES(768), .CONT_CYCLES(384)) u_acc_conv_cfg (
        .ref_clk_in(clk), .nrst_in(nrst), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
        .reg_wdata_in(wd), .reg_rdata_out(rdata), .reg_ack_out(ack), .reg_eeprom_addr_out(eep),
        .osc_in(osc), .ready_status_in(st), .continuous_in(cont), .ready_pin_in(plvl),
        .ready_pin_out(pout), .ready_pin_oe_out(poe), .mod_tick_out(tick), .chop_enable_out(chop),
        .line_reject_select_out(line_reject_select), .decimation_ratio_out(ratio), .conv_time_cycles_out(ctime),
        .amp_uses_aux_coef_out(amp), .aux_uses_aux_coef_out(aux));
    acc_far_end u_acc_far_end (.ref_clk_in(clk), .pin_oe_in(poe), .pin_drv_in(pout),
        .ext_lvl_in(ext), .osc_out(osc), .pin_lvl_out(plvl));
    always #4 clk = !clk;
    // ===============================
    function [9:0] eratio(input [7:0] x);
        eratio = ((x[3:2] == 2'h2) ? 640 : 768) >> x[1:0];
    endfunction
    function [23:0] etime(input [7:0] x);
        etime = (((cont ? 384 : 768) * eratio(x)) / 768) << x[6];
    endfunction
    task chk(input [23:0] g, input [23:0] e);
    begin
        total_checks = total_checks + 1;
        if (g !== e)
        begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    end
    endtask
    // one-cycle strobe, answer sampled after the taking edge
    task bus(input w, input [7:0] a, input [7:0] dd, input [7:0] e, input [7:0] m);
    begin
        @(posedge clk);
        wr   <= w;
        rd   <= !w;
        addr <= a;
        wd   <= dd;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 chk(ack, 1);
        if (!w)
            chk(rdata & m, e);
    end
    endtask
    task print_verdict;
    begin
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask
    // ===============================
    initial
    begin
        #320000;
        n_mismatch = n_mismatch + 1;
        print_verdict;
    end
    initial
    begin
        d = $urandom(32'hD60F);
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk) #1;
        chk(ratio, 768);
        chk({amp, aux, poe}, 3'h3);
        bus(0, 8'h13, 0, 0, 8'hFF);
        $display("reset test done");
        // rejection codes 0 to 2 with every decimation code, every divider code
        for (i = 0; i < 12; i = i + 1)
        begin
            d = ($urandom & 8'hC0) | ((i % 4) << 4) | ((i % 3) << 2) | (i / 3);
            @(posedge clk);
            cont <= $urandom;
            bus(1, 8'h13, d, 0, 0);
            bus(0, 8'h13, 0, d & 8'h7F, 8'hFF);
            chk(eep, 10'h005);
            repeat (2) @(posedge clk);
            #1 chk({chop, line_reject_select}, {d[6], d[3:2]});
            chk(ratio, eratio(d));
            chk(ctime, etime(d));
            c = 0;
            while (tick !== 1'b1 && c < 300)
            begin
                @(posedge clk);
                #1 c = c + 1;
            end
            @(posedge clk) #1 c = 1;
            while (tick !== 1'b1 && c < 300)
            begin
                @(posedge clk);
                #1 c = c + 1;
            end
            chk(c, 6 << (d[5:4] + 1));
        end
        $display("conversion test done");
        // pin functions 0..2 with direction from bit 1 of i, random level and swap bits
        for (i = 0; i < 12; i = i + 1)
        begin
            f = i % 3;
            d = ($urandom & 8'h41) | (i[1] << 7) | (f << 4);
            @(posedge clk);
            st  <= $urandom;
            ext <= $urandom;
            bus(1, 8'h14, d, 0, 0);
            repeat (4) @(posedge clk);
            #1 chk(poe, (f == 0) ? 1'b1 : (f == 1) ? !st : d[7]);
            if (poe === 1'b1) chk(pout, (f == 0) ? st : (f == 1) ? 1'b0 : d[6]);
            chk({amp, aux}, {d[0], !d[0]});
            if (f != 2) bus(0, 8'h14, 0, d & 8'hB1, 8'hB1);
            else if (d[7]) bus(0, 8'h14, 0, d & 8'hF1, 8'hFF);
            else bus(0, 8'h14, 0, (d & 8'hB1) | (ext << 6), 8'hFF);
            chk(eep, 10'h006);
        end
        $display("pin test done");
        bus(1, 8'h20, 8'hFF, 0, 0);
        bus(0, 8'h20, 0, 0, 8'hFF);
        bus(0, 8'h14, 0, d & 8'hB1, 8'hB1);
        $display("unmapped test done");
        print_verdict;
    end
endmodule
